// File: verilog/pfr_status_reg.sv
// Purpose: Processor flag register with ALU flag logic and APB access.
// Assumes: Core events are single-cycle pulses on CORE_CLK.
// Notes:   APB answers with no wait state.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "pfr_cfg.svh"

module pfr_status_reg #(
    parameter int ABITS = 12
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic OP_VALID,
    input wire pfr_pkg::pfr_op_t OP_KIND,
    input wire logic [7:0] OP_A,
    input wire logic [7:0] OP_B,
    input wire logic [7:0] OP_RESULT,
    input wire logic [7:0] OP_FILE_ADDR,
    input wire logic OP_DEST_FILE,
    input wire logic WDT_TIMEOUT,
    input wire logic WDT_KICK,
    input wire logic SLEEP_EXEC,
    input wire logic [6:0] DIRECT_ADDR,
    output logic [7:0] DATA_ADDR,
    output logic [7:0] FLAGS,
    output logic [7:0] RESULT,
    output logic IRQ,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ABITS-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);

    // ********************************
    // Decoding
    // ********************************
    function automatic logic is_flags_idx(input logic [7:0] idx);
        is_flags_idx = (idx == `PFR_FLAGS_IDX_LO) ||
                       (idx == `PFR_FLAGS_IDX_HI);
    endfunction

    logic [7:0] flags;
    logic [7:0] next_flags;
    logic [7:0] result;
    logic [7:0] next_result;
    logic [3:0] irq_status;
    logic [3:0] irq_enable;
    logic [3:0] next_irq_enable;
    logic [31:0] prdata;
    logic [31:0] next_prdata;
    logic [3:0] events;

    logic apb_setup;
    logic apb_access;
    logic apb_flags_hit;
    logic apb_known;
    logic core_flags_hit;

    // Mirror decode: index bits above the low byte must be zero
    assign apb_setup = PSEL && !PENABLE;
    assign apb_access = PSEL && PENABLE;
    assign apb_flags_hit = (PADDR[1:0] == 2'b00) &&
                           (PADDR[ABITS-1:10] == '0) &&
                           is_flags_idx(PADDR[9:2]);
    assign apb_known = apb_flags_hit ||
                       (PADDR == `PFR_IRQ_STATUS_ADDR) ||
                       (PADDR == `PFR_IRQ_CLEAR_ADDR) ||
                       (PADDR == `PFR_IRQ_ENABLE_ADDR);
    assign core_flags_hit = OP_VALID && OP_DEST_FILE &&
                            is_flags_idx(OP_FILE_ADDR);

    // ********************************
    // Arithmetic flags
    // ********************************
    logic is_sub;
    logic [7:0] addend;
    logic [8:0] sum;
    logic [4:0] nib_sum;
    logic [7:0] alu_res;
    logic [2:0] alu_flag;
    logic [2:0] aff_mask;

    // Subtraction adds the two's complement, so carry is a low-true borrow
    assign is_sub = (OP_KIND == pfr_pkg::PFR_OP_SUB);
    assign addend = is_sub ? ~OP_B : OP_B;
    assign sum = {1'b0, OP_A} + {1'b0, addend} + {8'h00, is_sub};
    assign nib_sum = {1'b0, OP_A[3:0]} + {1'b0, addend[3:0]} +
                     {4'h0, is_sub};

    always_comb begin
        alu_res = OP_RESULT;
        alu_flag = flags[2:0];
        aff_mask = 3'b000;
        unique case (OP_KIND)
            pfr_pkg::PFR_OP_ADD, pfr_pkg::PFR_OP_SUB: begin
                alu_res = sum[7:0];
                alu_flag[`PFR_BIT_CARRY] = sum[8];
                alu_flag[`PFR_BIT_NIBBLE] = nib_sum[4];
                alu_flag[`PFR_BIT_ZERO] = (sum[7:0] == 8'h00);
                aff_mask = 3'b111;
            end
            pfr_pkg::PFR_OP_ZLOGIC: begin
                alu_flag[`PFR_BIT_ZERO] = (OP_RESULT == 8'h00);
                aff_mask = 3'b100;
            end
            pfr_pkg::PFR_OP_ROT_RIGHT: begin
                alu_res = {flags[`PFR_BIT_CARRY], OP_A[7:1]};
                alu_flag[`PFR_BIT_CARRY] = OP_A[0];
                aff_mask = 3'b001;
            end
            pfr_pkg::PFR_OP_ROT_LEFT: begin
                alu_res = {OP_A[6:0], flags[`PFR_BIT_CARRY]};
                alu_flag[`PFR_BIT_CARRY] = OP_A[7];
                aff_mask = 3'b001;
            end
            pfr_pkg::PFR_OP_CLEAR: begin
                alu_res = 8'h00;
                alu_flag[`PFR_BIT_ZERO] = 1'b1;
                aff_mask = 3'b100;
            end
            pfr_pkg::PFR_OP_NOFLAG: begin
                aff_mask = 3'b000;
            end
        endcase
    end

    // ********************************
    // Flag register
    // ********************************
    // Instruction write beats an APB write in the same cycle; the core
    // owns the register and a lost APB write is the smaller surprise.
    always_comb begin
        next_flags = flags;
        next_result = result;
        if (apb_access && PWRITE && apb_flags_hit) begin
            next_flags[7:5] = PWDATA[7:5];
            next_flags[2:0] = PWDATA[2:0];
        end
        if (OP_VALID) begin
            next_result = alu_res;
            if (core_flags_hit) begin
                next_flags[7:5] = alu_res[7:5];
                next_flags[2:0] = (aff_mask == 3'b000) ? alu_res[2:0] :
                                  flags[2:0];
            end
            for (int i = 0; i < 3; i++) begin
                if (aff_mask[i]) begin
                    next_flags[i] = alu_flag[i];
                end
            end
        end
        // Reset-cause bits follow their events only, never a write
        if (WDT_KICK) begin
            next_flags[`PFR_BIT_WDOG] = 1'b1;
            next_flags[`PFR_BIT_SLEEP] = 1'b1;
        end
        if (SLEEP_EXEC) begin
            next_flags[`PFR_BIT_WDOG] = 1'b1;
            next_flags[`PFR_BIT_SLEEP] = 1'b0;
        end
        if (WDT_TIMEOUT) begin
            next_flags[`PFR_BIT_WDOG] = 1'b0;
        end
    end

    // Unknown ALU flags at power-up are held at zero here
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            flags <= `PFR_FLAGS_RST;
            result <= 8'h00;
        end else begin
            flags <= next_flags;
            result <= next_result;
        end
    end

    assign FLAGS = flags;
    assign RESULT = result;
    assign DATA_ADDR = {flags[`PFR_BIT_BANK], DIRECT_ADDR};

    // ********************************
    // Interrupt status
    // ********************************
    assign events[`PFR_EV_TIMEOUT] = WDT_TIMEOUT;
    assign events[`PFR_EV_SLEEP] = SLEEP_EXEC;
    assign events[`PFR_EV_KICK] = WDT_KICK;
    assign events[`PFR_EV_FLAGS_WR] = core_flags_hit;

    logic clr_write;
    assign clr_write = apb_access && PWRITE &&
                       (PADDR == `PFR_IRQ_CLEAR_ADDR);

    // An event in the clearing cycle survives: set wins over clear
    for (genvar g = 0; g < 4; g++) begin : g_sticky
        logic next_bit;
        always_comb begin
            next_bit = irq_status[g];
            if (clr_write && PWDATA[g]) begin
                next_bit = 1'b0;
            end
            if (events[g]) begin
                next_bit = 1'b1;
            end
        end
        always_ff @(posedge CORE_CLK or negedge RST_B) begin
            if (!RST_B) begin
                irq_status[g] <= 1'b0;
            end else begin
                irq_status[g] <= next_bit;
            end
        end
    end

    always_comb begin
        next_irq_enable = irq_enable;
        if (apb_access && PWRITE && (PADDR == `PFR_IRQ_ENABLE_ADDR)) begin
            next_irq_enable = PWDATA[3:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_enable <= `PFR_IRQ_RST;
        end else begin
            irq_enable <= next_irq_enable;
        end
    end

    assign IRQ = |(irq_status & irq_enable);

    // ********************************
    // APB read data
    // ********************************
    // Read data is captured in the setup cycle, so a read shows the
    // register as it stood one edge before the access completes.
    always_comb begin
        next_prdata = prdata;
        if (apb_setup && !PWRITE) begin
            next_prdata = 32'h0000_0000;
            if (apb_flags_hit) begin
                next_prdata = {24'h00_0000, flags};
            end else if (PADDR == `PFR_IRQ_STATUS_ADDR) begin
                next_prdata = {28'h000_0000, irq_status};
            end else if (PADDR == `PFR_IRQ_ENABLE_ADDR) begin
                next_prdata = {28'h000_0000, irq_enable};
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

    assign PRDATA = prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = apb_access && !apb_known;

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    sequence s_quiet;
        !WDT_KICK && !WDT_TIMEOUT && !SLEEP_EXEC;
    endsequence

    sequence s_kick_only;
        WDT_KICK && !WDT_TIMEOUT && !SLEEP_EXEC;
    endsequence

    sequence s_add_to_flags;
        OP_VALID && core_flags_hit && (OP_KIND == pfr_pkg::PFR_OP_ADD);
    endsequence

    AST_FLAG_MASK: assert property (
        s_add_to_flags |=>
            FLAGS[`PFR_BIT_CARRY] == $past(sum[8]) &&
            FLAGS[`PFR_BIT_ZERO] == ($past(sum[7:0]) == 8'h00))
        else $error("Flag bits took write data on an add");

    AST_NO_WRITE_CAUSE: assert property (
        (s_quiet and (apb_access && PWRITE && apb_flags_hit)) |=>
            $stable(FLAGS[4:3]))
        else $error("Reset-cause bits changed on a write");

    AST_CLEAR_FILE: assert property (
        (s_quiet and (core_flags_hit &&
            OP_KIND == pfr_pkg::PFR_OP_CLEAR)) |=>
            FLAGS[7:5] == 3'b000 && FLAGS[`PFR_BIT_ZERO] &&
            FLAGS[4:3] == $past(FLAGS[4:3]) &&
            FLAGS[1:0] == $past(FLAGS[1:0]))
        else $error("Clear of flag register gave wrong value");

    AST_BANK_ADDR: assert property (
        DATA_ADDR[7] == FLAGS[`PFR_BIT_BANK] &&
        DATA_ADDR[6:0] == DIRECT_ADDR)
        else $error("Direct address bank wrong");

    AST_WDOG_FLAG: assert property (
        (WDT_TIMEOUT |=> !FLAGS[`PFR_BIT_WDOG]) and
        ((WDT_KICK || SLEEP_EXEC) && !WDT_TIMEOUT |=>
            FLAGS[`PFR_BIT_WDOG]))
        else $error("Watchdog expired flag wrong");

    AST_SLEEP_FLAG: assert property (
        (SLEEP_EXEC |=> !FLAGS[`PFR_BIT_SLEEP]) and
        (s_kick_only |=> FLAGS[`PFR_BIT_SLEEP]))
        else $error("Sleep entered flag wrong");

    AST_ZERO_LOGIC: assert property (
        OP_VALID && !core_flags_hit &&
        OP_KIND == pfr_pkg::PFR_OP_ZLOGIC |=>
            FLAGS[`PFR_BIT_ZERO] == ($past(OP_RESULT) == 8'h00))
        else $error("Zero flag wrong after logic op");

    AST_SUB_BORROW: assert property (
        OP_VALID && !core_flags_hit &&
        OP_KIND == pfr_pkg::PFR_OP_SUB |=>
            FLAGS[`PFR_BIT_NIBBLE] ==
                ($past(OP_A[3:0]) >= $past(OP_B[3:0])) &&
            FLAGS[`PFR_BIT_CARRY] == ($past(OP_A) >= $past(OP_B)))
        else $error("Borrow flags wrong after subtract");

    AST_ROTATE: assert property (
        OP_VALID && !core_flags_hit &&
        OP_KIND == pfr_pkg::PFR_OP_ROT_RIGHT |=>
            FLAGS[`PFR_BIT_CARRY] == $past(OP_A[0]) &&
            RESULT == {$past(FLAGS[0]), $past(OP_A[7:1])})
        else $error("Rotate carry wrong");

    AST_RESET_VALUE: assert property (
        $rose(RST_B) |-> FLAGS[5:3] == 3'b011)
        else $error("Flag register reset value wrong");

    AST_MIRROR_READ: assert property (
        apb_setup && !PWRITE && apb_flags_hit |=>
            PRDATA == {24'h00_0000, $past(FLAGS)} ##0 PREADY)
        else $error("Mirrored read returned wrong data");

    AST_PLAIN_WRITE: assert property (
        (s_quiet and (core_flags_hit &&
            OP_KIND == pfr_pkg::PFR_OP_NOFLAG)) |=>
            FLAGS[2:0] == $past(OP_RESULT[2:0]))
        else $error("Flag-neutral write not stored");

endmodule

// File: verilog/pfr_cfg.svh
// Purpose: Offsets, field positions and reset values of the flag register.
// Assumes: APB byte addresses, 12-bit address bus.
// Notes:   Definitions only.
`ifndef PFR_CFG_SVH
`define PFR_CFG_SVH

// ********************************
// Register map
// ********************************
`define PFR_FLAGS_IDX_LO 8'h03
`define PFR_FLAGS_IDX_HI 8'h83
`define PFR_IRQ_STATUS_ADDR 12'h400
`define PFR_IRQ_CLEAR_ADDR 12'h404
`define PFR_IRQ_ENABLE_ADDR 12'h408

// ********************************
// Field positions
// ********************************
`define PFR_BIT_CARRY 0
`define PFR_BIT_NIBBLE 1
`define PFR_BIT_ZERO 2
`define PFR_BIT_SLEEP 3
`define PFR_BIT_WDOG 4
`define PFR_BIT_BANK 5

`define PFR_EV_TIMEOUT 0
`define PFR_EV_SLEEP 1
`define PFR_EV_KICK 2
`define PFR_EV_FLAGS_WR 3

// ********************************
// Reset values
// ********************************
`define PFR_FLAGS_RST 8'h18
`define PFR_IRQ_RST 4'h0

`endif

// File: verilog/pfr_pkg.sv
// Purpose: Types shared by the flag register block.
// Assumes: Nothing beyond the core clock.
// Notes:   Constants live in pfr_cfg.svh.
package pfr_pkg;

    // Kind of instruction that the core executes this cycle
    typedef enum logic [2:0] {
        PFR_OP_ADD,
        PFR_OP_SUB,
        PFR_OP_ZLOGIC,
        PFR_OP_ROT_RIGHT,
        PFR_OP_ROT_LEFT,
        PFR_OP_CLEAR,
        PFR_OP_NOFLAG
    } pfr_op_t;

endpackage

// File: bench/pfr_status_reg_tb.sv
// Purpose: Self-checking bench for the processor flag register.
// Assumes: Zero-wait APB slave; core events are one-cycle pulses.
// Notes:   Expected values are worked out by hand from the flag rules.
`timescale 1ns/1ps

module pfr_status_reg_tb;
    localparam pfr_pkg::pfr_op_t k_add = pfr_pkg::PFR_OP_ADD;
    localparam pfr_pkg::pfr_op_t k_sub = pfr_pkg::PFR_OP_SUB;
    localparam pfr_pkg::pfr_op_t k_zl = pfr_pkg::PFR_OP_ZLOGIC;
    localparam pfr_pkg::pfr_op_t k_rr = pfr_pkg::PFR_OP_ROT_RIGHT;
    localparam pfr_pkg::pfr_op_t k_rl = pfr_pkg::PFR_OP_ROT_LEFT;
    localparam pfr_pkg::pfr_op_t k_clr = pfr_pkg::PFR_OP_CLEAR;
    localparam pfr_pkg::pfr_op_t k_nf = pfr_pkg::PFR_OP_NOFLAG;
    logic clk, rst_b, op_valid, op_dest, wdt_to, wdt_kick, sleep_ex;
    pfr_pkg::pfr_op_t op_kind;
    logic [7:0] op_a, op_b, op_res, op_fa, data_addr, flags, result;
    logic [6:0] direct_addr;
    logic irq, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int n_mismatch, cmp_count;

    pfr_status_reg #(.ABITS(12)) i_dut (
        .CORE_CLK(clk), .RST_B(rst_b), .OP_VALID(op_valid),
        .OP_KIND(op_kind), .OP_A(op_a), .OP_B(op_b), .OP_RESULT(op_res),
        .OP_FILE_ADDR(op_fa), .OP_DEST_FILE(op_dest), .WDT_TIMEOUT(wdt_to),
        .WDT_KICK(wdt_kick), .SLEEP_EXEC(sleep_ex),
        .DIRECT_ADDR(direct_addr), .DATA_ADDR(data_addr), .FLAGS(flags),
        .RESULT(result), .IRQ(irq), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ********************************
    // Checking and access tasks
    // ********************************
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Ends one edge after release so the next setup never doubles a drive
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a,
                          input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask

    task automatic op(input pfr_pkg::pfr_op_t k, input logic [7:0] a, b, r,
                      input logic dst, input logic [7:0] fa, eres, efl);
        op_valid <= 1'b1;
        op_kind <= k;
        op_a <= a;
        op_b <= b;
        op_res <= r;
        op_dest <= dst;
        op_fa <= fa;
        @(posedge clk);
        op_valid <= 1'b0;
        op_dest <= 1'b0;
        @(posedge clk);
        chk("result", {24'h0, eres}, {24'h0, result});
        chk("flags", {24'h0, efl}, {24'h0, flags});
    endtask

    // The second extra edge is spare: IRQ is decoded from the registered status with no further register
    task automatic ev(input logic t, k, s, input logic [7:0] efl,
                      input logic eirq);
        wdt_to <= t;
        wdt_kick <= k;
        sleep_ex <= s;
        @(posedge clk);
        wdt_to <= 1'b0;
        wdt_kick <= 1'b0;
        sleep_ex <= 1'b0;
        repeat (2) @(posedge clk);
        chk("flags", {24'h0, efl}, {24'h0, flags});
        chk("irq", {31'h0, eirq}, {31'h0, irq});
    endtask

    task automatic irq_chk(input logic e);
        @(posedge clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        rst_b = 1'b0;
        {op_valid, op_dest, wdt_to, wdt_kick, sleep_ex} = 5'h00;
        op_kind = k_nf;
        {op_a, op_b, op_res, op_fa} = 32'h0;
        direct_addr = 7'h12;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("flags", 32'h18, {24'h0, flags});
        chk("irq", 32'h0, {31'h0, irq});
        chk("pready", 32'h1, {31'h0, pready});
        rd_chk("flags lo", 12'h00c, 32'h18);
        rd_chk("flags hi", 12'h20c, 32'h18);
        apb(1'b1, 12'h00c, 32'h00);
        chk("flags", 32'h18, {24'h0, flags});
        apb(1'b1, 12'h20c, 32'h27);
        chk("flags", 32'h3f, {24'h0, flags});
        chk("data addr", 32'h92, {24'h0, data_addr});
        rd_chk("flags lo", 12'h00c, 32'h3f);
        // Instructions aimed at the flag register itself
        op(k_clr, 8'h00, 8'h00, 8'h00, 1'b1, 8'h83, 8'h00, 8'h1f);
        op(k_nf, 8'h00, 8'h00, 8'h24, 1'b1, 8'h03, 8'h24, 8'h3c);
        op(k_add, 8'h0f, 8'h11, 8'h00, 1'b1, 8'h03, 8'h20, 8'h3a);
        op(k_zl, 8'h00, 8'h00, 8'h07, 1'b1, 8'h83, 8'h07, 8'h1a);
        apb(1'b1, 12'h00c, 32'h00);
        chk("data addr", 32'h12, {24'h0, data_addr});
        // ALU flags with the result going elsewhere
        op(k_add, 8'h0f, 8'h01, 8'h00, 1'b0, 8'h20, 8'h10, 8'h1a);
        op(k_add, 8'hff, 8'h01, 8'h00, 1'b0, 8'h20, 8'h00, 8'h1f);
        op(k_add, 8'h80, 8'h80, 8'h00, 1'b0, 8'h20, 8'h00, 8'h1d);
        op(k_sub, 8'h05, 8'h03, 8'h00, 1'b0, 8'h20, 8'h02, 8'h1b);
        op(k_sub, 8'h03, 8'h05, 8'h00, 1'b0, 8'h20, 8'hfe, 8'h18);
        op(k_sub, 8'h10, 8'h01, 8'h00, 1'b0, 8'h20, 8'h0f, 8'h19);
        op(k_zl, 8'h00, 8'h00, 8'h00, 1'b0, 8'h20, 8'h00, 8'h1d);
        op(k_zl, 8'h00, 8'h00, 8'h5a, 1'b0, 8'h20, 8'h5a, 8'h19);
        op(k_rr, 8'h02, 8'h00, 8'h00, 1'b0, 8'h20, 8'h81, 8'h18);
        op(k_rl, 8'h80, 8'h00, 8'h00, 1'b0, 8'h20, 8'h00, 8'h19);
        op(k_rr, 8'h01, 8'h00, 8'h00, 1'b0, 8'h20, 8'h80, 8'h19);
        op(k_nf, 8'h00, 8'h00, 8'h00, 1'b0, 8'h20, 8'h00, 8'h19);
        op(k_clr, 8'h00, 8'h00, 8'h00, 1'b0, 8'h20, 8'h00, 8'h1d);
        // Reset-cause events and the interrupt registers
        rd_chk("irq status", 12'h400, 32'h8);
        apb(1'b1, 12'h404, 32'hf);
        rd_chk("irq status", 12'h400, 32'h0);
        apb(1'b1, 12'h408, 32'hf);
        rd_chk("irq enable", 12'h408, 32'hf);
        ev(1'b0, 1'b0, 1'b1, 8'h15, 1'b1);
        rd_chk("irq status", 12'h400, 32'h2);
        apb(1'b1, 12'h404, 32'h2);
        irq_chk(1'b0);
        ev(1'b1, 1'b0, 1'b0, 8'h05, 1'b1);
        ev(1'b0, 1'b1, 1'b0, 8'h1d, 1'b1);
        ev(1'b1, 1'b1, 1'b0, 8'h0d, 1'b1);
        rd_chk("irq status", 12'h400, 32'h5);
        apb(1'b1, 12'h408, 32'h0);
        irq_chk(1'b0);
        apb(1'b1, 12'h404, 32'hf);
        apb(1'b1, 12'h400, 32'hf);
        rd_chk("irq status", 12'h400, 32'h0);
        apb(1'b1, 12'h00c, 32'h00);
        chk("flags", 32'h08, {24'h0, flags});
        rd_chk("unmapped", 12'h100, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        final_report();
    end
endmodule
